// ---- pgm_regbank.sv ----
// Gain readback registers and monitor output control, top of the block.
// What this block does
// [R1] Current-loop integral gain in use reads in bits 31-16, resets to zero.
// [R2] Current-loop proportional gain in use reads in bits 15-0, resets to zero.
// [R3] Current gain readbacks use the same scaling as their configuration fields.
// [R4] Speed-loop integral gain in use reads in bits 31-16, configuration scaling.
// [R5] Speed-loop proportional gain in use reads in bits 15-0, configuration scaling.
// [R6] Monitor control bits 11-0 hold the read/write variable address.
// [R7] Scale field bits 16-13 multiplies variable by code/8; resets to 8h.
// [R8] Scale code zero treats the variable as an enumeration limited to 31.
// [R9] Bits 20-17 multiply by two to the field, only with scale zero.
// [R10] Polarity bit 12 clear: bipolar, -1pu to 0 V, +1pu to 3 V.
// [R11] Polarity bit 12 set: unipolar, 0pu to 0 V, 1pu to 3 V.
// [R12] Monitor control resets to 00110000h; bits 31-21 read zero.
// [R13] Nonzero scale codes divide by 8, as the scale code table defines; enumeration mode (scale zero) does not.
`timescale 1ns/10ps
`default_nettype none
`include "pgm_params.svh"

module pgm_regbank (
    input wire logic clk_sys,
    input wire logic srst,
    input wire pgm_pkg::pgm_reg_req_s reg_req,
    output logic [31:0] reg_rd_data,
    output logic reg_rd_valid,
    input wire logic gain_update,
    input wire logic [15:0] cur_integral_gain_used,
    input wire logic [15:0] cur_proportional_gain_used,
    input wire logic [15:0] spd_integral_gain_used,
    input wire logic [15:0] spd_proportional_gain_used,
    output logic [11:0] monitor_variable_address,
    output logic var_rd_req,
    input wire logic [31:0] var_rd_data,
    input wire logic var_rd_valid,
    output logic [11:0] monitor_output_pin,
    output logic monitor_out_update,
    output logic monitor_fetch_timeout
);

    // ------------------------------------------------------------------------
    // Constants and helpers
    // ------------------------------------------------------------------------
    localparam logic [7:0] REFRESH_LAST = 8'(`PGM_REFRESH_CYC - 1);
    localparam logic [5:0] TIMEOUT_LAST = 6'(`PGM_FETCH_TIMEOUT_CYC - 1);

    // Address decode is needed by both the read and the write path.
    function automatic logic [1:0] decode_reg(input logic [11:0] addr);
        logic [1:0] sel;
        sel = 2'h0;
        case (addr)
            `PGM_OFF_CUR_GAIN: sel = 2'h1;
            `PGM_OFF_SPD_GAIN: sel = 2'h2;
            `PGM_OFF_MON_CTRL: sel = 2'h3;
            default: sel = 2'h0;
        endcase
        return sel;
    endfunction : decode_reg

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    logic [31:0] cur_gain_reg;
    logic [31:0] spd_gain_reg;
    pgm_pkg::pgm_mon_cfg_s mon_cfg_reg;
    pgm_pkg::pgm_mon_cfg_s mon_cfg_next;
    pgm_pkg::pgm_mon_cfg_s mon_cfg_rst;
    logic [31:0] mon_ctrl_word;
    logic [1:0] wr_sel;
    logic [1:0] rd_sel;
    logic cfg_write;

    assign mon_cfg_rst = pgm_pkg::pgm_mon_cfg_s'(21'(`PGM_MON_CTRL_RST));
    assign wr_sel = decode_reg(reg_req.addr);
    assign rd_sel = decode_reg(reg_req.addr);
    assign cfg_write = reg_req.wr_en && (wr_sel == 2'h3);

    // ------------------------------------------------------------------------
    // Gain readback capture
    // ------------------------------------------------------------------------
    // Gains are copied as raw fields with no rescaling, so software compares them
    // bit for bit with the configured values. They only move on gain_update so a
    // register read never sees a pair torn across two loop updates.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cur_gain_reg <= `PGM_GAIN_RST; // see [R1]
        end else if (gain_update) begin
            cur_gain_reg[`PGM_GAIN_INT_MSB:`PGM_GAIN_INT_LSB] <= cur_integral_gain_used; // see [R1]
            cur_gain_reg[`PGM_GAIN_PROP_MSB:`PGM_GAIN_PROP_LSB] <= cur_proportional_gain_used; // see [R2]
        end
    end

    // Same raw copy for the speed loop, matching its configuration scaling.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            spd_gain_reg <= `PGM_GAIN_RST;
        end else if (gain_update) begin
            spd_gain_reg[`PGM_GAIN_INT_MSB:`PGM_GAIN_INT_LSB] <= spd_integral_gain_used; // see [R4]
            spd_gain_reg[`PGM_GAIN_PROP_MSB:`PGM_GAIN_PROP_LSB] <= spd_proportional_gain_used; // see [R5]
        end
    end

    // ------------------------------------------------------------------------
    // Monitor control register
    // ------------------------------------------------------------------------
    // Writes to the readback registers and to unmapped addresses are dropped.
    assign mon_cfg_next = pgm_pkg::pgm_mon_cfg_s'(reg_req.wdata[`PGM_MON_CFG_MSB:0]); // see [R6]

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mon_cfg_reg <= mon_cfg_rst; // see [R12]
        end else if (cfg_write) begin
            mon_cfg_reg <= mon_cfg_next; // see [R7]
        end
    end

    assign mon_ctrl_word = {`PGM_MON_RSVD_ZERO, mon_cfg_reg}; // see [R12]
    assign monitor_variable_address = mon_cfg_reg.var_addr; // see [R6]

    // ------------------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------------------
    // Read data are registered and valid one cycle after the request; an
    // unmapped address answers with zero so the interface never stalls.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rd_data <= 32'h00000000;
        end else if (reg_req.rd_en) begin
            case (rd_sel)
                2'h1: reg_rd_data <= cur_gain_reg; // see [R3]
                2'h2: reg_rd_data <= spd_gain_reg;
                2'h3: reg_rd_data <= mon_ctrl_word;
                default: reg_rd_data <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_req.rd_en;
        end
    end

    // ------------------------------------------------------------------------
    // Refresh timer
    // ------------------------------------------------------------------------
    logic [7:0] refresh_cnt_reg;
    logic refresh_due_reg;
    logic fetch_start;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            refresh_cnt_reg <= 8'h00;
        end else if (refresh_cnt_reg == REFRESH_LAST) begin
            refresh_cnt_reg <= 8'h00;
        end else begin
            refresh_cnt_reg <= refresh_cnt_reg + 8'h01;
        end
    end

    // A control write must show on the pin without waiting a whole period, so
    // it raises the same pending flag as the timer. The set wins over the clear.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            refresh_due_reg <= 1'b1;
        end else if ((refresh_cnt_reg == REFRESH_LAST) || cfg_write) begin
            refresh_due_reg <= 1'b1;
        end else if (fetch_start) begin
            refresh_due_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Variable fetch sequencer
    // ------------------------------------------------------------------------
    pgm_pkg::pgm_fetch_e fetch_state_reg;
    pgm_pkg::pgm_fetch_e fetch_state_next;
    logic [5:0] wait_cnt_reg;
    logic [31:0] var_value_reg;
    logic scale_start;
    logic wait_expired;

    assign wait_expired = (wait_cnt_reg == TIMEOUT_LAST);
    assign fetch_start = (fetch_state_reg == pgm_pkg::PGM_FETCH_IDLE) && refresh_due_reg;
    assign scale_start = (fetch_state_reg == pgm_pkg::PGM_FETCH_SCALE);

    always_comb begin
        fetch_state_next = fetch_state_reg;
        case (fetch_state_reg)
            pgm_pkg::PGM_FETCH_IDLE: begin
                if (refresh_due_reg) begin
                    fetch_state_next = pgm_pkg::PGM_FETCH_REQ;
                end
            end
            pgm_pkg::PGM_FETCH_REQ: begin
                fetch_state_next = pgm_pkg::PGM_FETCH_WAIT;
            end
            pgm_pkg::PGM_FETCH_WAIT: begin
                if (var_rd_valid) begin
                    fetch_state_next = pgm_pkg::PGM_FETCH_SCALE;
                end else if (wait_expired) begin
                    fetch_state_next = pgm_pkg::PGM_FETCH_IDLE;
                end
            end
            pgm_pkg::PGM_FETCH_SCALE: begin
                fetch_state_next = pgm_pkg::PGM_FETCH_IDLE;
            end
            default: begin
                fetch_state_next = pgm_pkg::PGM_FETCH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fetch_state_reg <= pgm_pkg::PGM_FETCH_IDLE;
        end else begin
            fetch_state_reg <= fetch_state_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wait_cnt_reg <= 6'h00;
        end else if (fetch_state_reg == pgm_pkg::PGM_FETCH_WAIT) begin
            wait_cnt_reg <= wait_cnt_reg + 6'h01;
        end else begin
            wait_cnt_reg <= 6'h00;
        end
    end

    // The variable is latched on its valid strobe so the scaler sees a stable word.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            var_value_reg <= 32'h00000000;
        end else if ((fetch_state_reg == pgm_pkg::PGM_FETCH_WAIT) && var_rd_valid) begin
            var_value_reg <= var_rd_data;
        end
    end

    assign var_rd_req = (fetch_state_reg == pgm_pkg::PGM_FETCH_REQ);

    // A missing answer leaves the last code on the pin; only a pulse reports it.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            monitor_fetch_timeout <= 1'b0;
        end else begin
            monitor_fetch_timeout <= (fetch_state_reg == pgm_pkg::PGM_FETCH_WAIT)
                && !var_rd_valid && wait_expired;
        end
    end

    // ------------------------------------------------------------------------
    // Scaling and output code
    // ------------------------------------------------------------------------
    // The configuration is read live at scale time, so a write that lands
    // during a fetch is used at once and the pending flag re-runs the fetch.
    pgm_monitor_scaler u_scaler (
        .clk_sys(clk_sys),
        .srst(srst),
        .start(scale_start),
        .cfg(mon_cfg_reg), // see [R10]
        .var_value(var_value_reg),
        .code(monitor_output_pin), // see [R11]
        .done(monitor_out_update)
    );

endmodule : pgm_regbank
`default_nettype wire

// ---- pgm_params.svh ----
// Offsets, field positions, reset values and timing counts of the gain readback and monitor block.
`ifndef PGM_PARAMS_SVH
`define PGM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (register index as printed)
// ----------------------------------------------------------------------------
`define PGM_OFF_CUR_GAIN 12'h0F0
`define PGM_OFF_SPD_GAIN 12'h0F2
`define PGM_OFF_MON_CTRL 12'h0F4

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define PGM_GAIN_INT_MSB 31
`define PGM_GAIN_INT_LSB 16
`define PGM_GAIN_PROP_MSB 15
`define PGM_GAIN_PROP_LSB 0
`define PGM_MON_CFG_MSB 20
`define PGM_GAIN_RST 32'h00000000
`define PGM_MON_CTRL_RST 32'h00110000
`define PGM_MON_RSVD_ZERO 11'h000

// ----------------------------------------------------------------------------
// Number formats of the monitor path
// ----------------------------------------------------------------------------
`define PGM_SCALE_DIV_SHIFT 3
`define PGM_UNI_SHIFT 15
`define PGM_BI_SHIFT 16
`define PGM_DAC_MID 40'sh0000000800
`define PGM_DAC_MAX 40'sh0000000FFF
`define PGM_ENUM_MAX 32'sh0000001F

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PGM_CLK_PERIOD_NS 50
`define PGM_REFRESH_NS 10000
`define PGM_REFRESH_CYC (`PGM_REFRESH_NS / `PGM_CLK_PERIOD_NS)
`define PGM_FETCH_TIMEOUT_NS 2000
`define PGM_FETCH_TIMEOUT_CYC (`PGM_FETCH_TIMEOUT_NS / `PGM_CLK_PERIOD_NS)

`endif

// ---- pgm_pkg.sv ----
// Types shared by the gain readback and monitor block.
`default_nettype none
package pgm_pkg;

    // ------------------------------------------------------------------------
    // Register access request from the serial register interface
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [11:0] addr;
        logic [31:0] wdata;
    } pgm_reg_req_s;

    // ------------------------------------------------------------------------
    // Monitor control fields, laid out exactly as bits 20-0 of the register
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] enum_mult;
        logic [3:0] scale;
        logic polarity;
        logic [11:0] var_addr;
    } pgm_mon_cfg_s;

    // ------------------------------------------------------------------------
    // Variable fetch sequencer
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        PGM_FETCH_IDLE,
        PGM_FETCH_REQ,
        PGM_FETCH_WAIT,
        PGM_FETCH_SCALE
    } pgm_fetch_e;

endpackage : pgm_pkg
`default_nettype wire

// ---- pgm_monitor_scaler.sv ----
// Scaling of one algorithm variable into a monitor output code.
`timescale 1ns/10ps
`default_nettype none
`include "pgm_params.svh"

module pgm_monitor_scaler (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic start,
    input wire pgm_pkg::pgm_mon_cfg_s cfg,
    input wire logic [31:0] var_value,
    output logic [11:0] code,
    output logic done
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Saturation keeps an overdriven variable pinned at a rail instead of wrapping.
    function automatic logic [11:0] clamp_code(input logic signed [39:0] v);
        logic [11:0] r;
        r = 12'h000;
        if (v < 40'sh0000000000) begin
            r = 12'h000;
        end else if (v > `PGM_DAC_MAX) begin
            r = 12'hFFF;
        end else begin
            r = v[11:0];
        end
        return r;
    endfunction : clamp_code

    logic signed [31:0] var_s;
    logic signed [36:0] frac_prod;
    logic signed [39:0] frac_uni;
    logic signed [39:0] frac_bi;
    logic signed [31:0] enum_val;
    logic signed [39:0] enum_shift;
    logic [11:0] code_next;

    // ------------------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------------------
    assign var_s = var_value;
    assign frac_prod = 37'(var_s) * 37'($signed({1'b0, cfg.scale})); // see [R7]
    // The divide by 8 is folded into the shifts below, so 8h gives unity gain.
    assign frac_uni = 40'(frac_prod >>> `PGM_UNI_SHIFT); // see [R13]
    assign frac_bi = 40'(frac_prod >>> `PGM_BI_SHIFT) + `PGM_DAC_MID; // see [R13]

    always_comb begin
        enum_val = var_s;
        if (var_s > `PGM_ENUM_MAX) begin
            enum_val = `PGM_ENUM_MAX; // see [R8]
        end else if (var_s < 32'sh00000000) begin
            enum_val = 32'sh00000000;
        end
    end

    assign enum_shift = 40'(enum_val) <<< cfg.enum_mult; // see [R9]

    always_comb begin
        code_next = 12'h000;
        if (cfg.scale == 4'h0) begin
            if (cfg.polarity) begin
                code_next = clamp_code(enum_shift); // see [R8]
            end else begin
                code_next = clamp_code(enum_shift + `PGM_DAC_MID);
            end
        end else if (cfg.polarity) begin
            code_next = clamp_code(frac_uni); // see [R11]
        end else begin
            code_next = clamp_code(frac_bi); // see [R10]
        end
    end

    // ------------------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            code <= 12'h800;
        end else if (start) begin
            code <= code_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            done <= 1'b0;
        end else begin
            done <= start;
        end
    end

endmodule : pgm_monitor_scaler
`default_nettype wire

// ---- pgm_regbank_properties.sv ----
// Concurrent checks on the ports of the gain readback and monitor block.
`timescale 1ns/10ps
`default_nettype none
`include "pgm_params.svh"

module pgm_regbank_properties (
    input wire logic clk_sys,
    input wire logic srst,
    input wire pgm_pkg::pgm_reg_req_s reg_req,
    input wire logic [31:0] reg_rd_data,
    input wire logic reg_rd_valid,
    input wire logic gain_update,
    input wire logic [15:0] cur_integral_gain_used,
    input wire logic [15:0] cur_proportional_gain_used,
    input wire logic [15:0] spd_integral_gain_used,
    input wire logic [15:0] spd_proportional_gain_used,
    input wire logic [11:0] monitor_variable_address,
    input wire logic var_rd_req,
    input wire logic [31:0] var_rd_data,
    input wire logic var_rd_valid,
    input wire logic [11:0] monitor_output_pin,
    input wire logic monitor_out_update,
    input wire logic monitor_fetch_timeout
);
    logic [31:0] cur_m;
    logic [31:0] spd_m;
    logic [31:0] mon_m;
    logic busy;
    logic [6:0] wcnt;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cur_m <= `PGM_GAIN_RST;
            spd_m <= `PGM_GAIN_RST;
        end else if (gain_update) begin
            cur_m <= {cur_integral_gain_used, cur_proportional_gain_used};
            spd_m <= {spd_integral_gain_used, spd_proportional_gain_used};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mon_m <= `PGM_MON_CTRL_RST;
        end else if (reg_req.wr_en && reg_req.addr == `PGM_OFF_MON_CTRL) begin
            mon_m <= {11'h000, reg_req.wdata[20:0]};
        end
    end

    // Counts wait cycles of a fetch; it keeps running after a timeout, which is harmless.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            busy <= 1'b0;
            wcnt <= 7'h00;
        end else if (var_rd_req) begin
            busy <= 1'b1;
            wcnt <= 7'h00;
        end else if (busy) begin
            busy <= !var_rd_valid;
            wcnt <= wcnt + 7'h01;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_read(a);
        reg_req.rd_en && reg_req.addr == a;
    endsequence
    sequence s_fetch;
        var_rd_req ##1 var_rd_valid;
    endsequence

    property p_rd_answer;
        reg_rd_valid == $past(reg_req.rd_en);
    endproperty
    property p_cur;
        s_read(`PGM_OFF_CUR_GAIN) |=> reg_rd_data == $past(cur_m);
    endproperty
    property p_spd;
        s_read(`PGM_OFF_SPD_GAIN) |=> reg_rd_data == $past(spd_m);
    endproperty
    property p_mon;
        s_read(`PGM_OFF_MON_CTRL) |=> reg_rd_data == $past(mon_m);
    endproperty
    property p_addr;
        monitor_variable_address == mon_m[11:0];
    endproperty
    property p_reset;
        $fell(srst) |-> monitor_output_pin == 12'h800 && !monitor_out_update;
    endproperty
    property p_update;
        s_fetch |-> ##2 monitor_out_update;
    endproperty
    property p_hold;
        !monitor_out_update && !$past(srst) |-> $stable(monitor_output_pin);
    endproperty
    property p_timeout;
        monitor_fetch_timeout |-> busy && wcnt inside {[39:41]} && !monitor_out_update;
    endproperty

    a_rd_answer: assert property (p_rd_answer) else $error("read answer missing or spurious");
    a_cur: assert property (p_cur) else $error("current gain readback wrong");
    a_spd: assert property (p_spd) else $error("speed gain readback wrong");
    a_mon: assert property (p_mon) else $error("monitor control readback wrong");
    a_addr: assert property (p_addr) else $error("variable address output wrong");
    a_reset: assert property (p_reset) else $error("monitor output not at midscale after reset");
    a_update: assert property (p_update) else $error("monitor output not updated after answer");
    a_hold: assert property (p_hold) else $error("monitor output changed without update");
    a_timeout: assert property (p_timeout) else $error("fetch timeout at wrong moment");
endmodule : pgm_regbank_properties
`default_nettype wire

// ---- pgm_regbank_test.sv ----
// Self-checking bench for the gain readback and monitor block.
`timescale 1ns/10ps
`default_nettype none
`include "pgm_params.svh"

module pgm_regbank_test;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    pgm_pkg::pgm_reg_req_s reg_req = '0;
    logic [31:0] reg_rd_data;
    logic reg_rd_valid;
    logic gain_update = 1'b0;
    logic [15:0] cki = '0, ckp = '0, ski = '0, skp = '0;
    logic [11:0] monitor_variable_address;
    logic var_rd_req;
    logic [31:0] var_rd_data = '0;
    logic var_rd_valid = 1'b0;
    logic [11:0] monitor_output_pin;
    logic monitor_out_update;
    logic monitor_fetch_timeout;
    logic [31:0] var_value = '0;
    logic mute = 1'b0;
    logic req_prev = 1'b0;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;

    pgm_regbank u_dut (.clk_sys(clk_sys), .srst(srst), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .gain_update(gain_update), .cur_integral_gain_used(cki),
        .cur_proportional_gain_used(ckp), .spd_integral_gain_used(ski), .spd_proportional_gain_used(skp),
        .monitor_variable_address(monitor_variable_address), .var_rd_req(var_rd_req),
        .var_rd_data(var_rd_data), .var_rd_valid(var_rd_valid), .monitor_output_pin(monitor_output_pin),
        .monitor_out_update(monitor_out_update), .monitor_fetch_timeout(monitor_fetch_timeout));

    always #25 clk_sys = ~clk_sys;

    // Variable map stand-in: answers one cycle after each request unless muted.
    always @(posedge clk_sys) begin
        #1;
        var_rd_valid = req_prev && !mute;
        var_rd_data = var_rd_valid ? var_value : ~var_value;
        req_prev = var_rd_req;
    end

    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            end_of_test();
        end
    end

    // ----
    // Helpers
    // ----
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask : step

    task automatic acc(input logic rd, input logic wr, input logic [11:0] a, input logic [31:0] d);
        step();
        reg_req = '{rd_en: rd, wr_en: wr, addr: a, wdata: d};
        step();
        reg_req = '0;
    endtask : acc

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        acc(1'b1, 1'b0, a, 32'h00000000);
        check({reg_rd_valid, reg_rd_data}, {1'b1, exp}, "read");
    endtask : rd_chk

    function automatic logic [11:0] exp_code(input logic [31:0] c, input logic signed [31:0] v);
        logic signed [47:0] x;
        if (c[16:13] != 4'h0) begin
            x = (v * $signed({1'b0, c[16:13]})) >>> (c[12] ? 15 : 16);
        end else begin
            x = (v > 31 ? 31 : (v < 0 ? 0 : v)) <<< c[20:17];
        end
        if (!c[12]) begin
            x = x + 2048;
        end
        exp_code = x < 0 ? 12'h000 : (x > 4095 ? 12'hFFF : x[11:0]);
    endfunction : exp_code

    // Waits for a fetch launched after the write, so the new settings are the ones scaled.
    task automatic mon_case(input logic [31:0] c, input logic [31:0] v);
        int n;
        var_value = v;
        acc(1'b0, 1'b1, `PGM_OFF_MON_CTRL, c);
        check(monitor_variable_address, c[11:0], "address");
        for (n = 0; n < 300 && var_rd_req !== 1'b1; n++) step();
        for (n = 0; n < 10 && monitor_out_update !== 1'b1; n++) step();
        check(monitor_output_pin, exp_code(c, v), "code");
    endtask : mon_case

    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        check(monitor_output_pin, 12'h800, "pin reset");
        rd_chk(`PGM_OFF_CUR_GAIN, 32'h00000000);
        rd_chk(`PGM_OFF_SPD_GAIN, 32'h00000000);
        rd_chk(`PGM_OFF_MON_CTRL, 32'h00110000);
    endtask : t_reset

    task automatic t_gains();
        step();
        {cki, ckp, ski, skp} = 64'hA5C33C5AFFFF0001;
        gain_update = 1'b1;
        step();
        gain_update = 1'b0;
        {cki, ckp, ski, skp} = 64'h0000000000000000;
        rd_chk(`PGM_OFF_CUR_GAIN, 32'hA5C33C5A);
        acc(1'b0, 1'b1, `PGM_OFF_CUR_GAIN, 32'h12345678);
        acc(1'b0, 1'b1, `PGM_OFF_SPD_GAIN, 32'h12345678);
        rd_chk(`PGM_OFF_CUR_GAIN, 32'hA5C33C5A);
        rd_chk(`PGM_OFF_SPD_GAIN, 32'hFFFF0001);
        rd_chk(12'h0F6, 32'h00000000);
    endtask : t_gains

    task automatic t_ctrl();
        acc(1'b0, 1'b1, `PGM_OFF_MON_CTRL, 32'hFFFFFFFF);
        check(monitor_variable_address, 12'hFFF, "address");
        rd_chk(`PGM_OFF_MON_CTRL, 32'h001FFFFF);
        acc(1'b1, 1'b1, `PGM_OFF_MON_CTRL, 32'h00110000);
        check(reg_rd_data, 32'h001FFFFF, "old value");
        rd_chk(`PGM_OFF_MON_CTRL, 32'h00110000);
    endtask : t_ctrl

    task automatic t_monitor();
        logic [31:0] tc[7] = '{32'h00110000, 32'h00110000, 32'h00001000, 32'h001E1000,
            32'h00000000, 32'h00100000, 32'h00001000};
        logic [31:0] tv[7] = '{32'h01000000, 32'hFF000000, 32'hFFFFFFFB, 32'h0000001F,
            32'h00000007, 32'h00000003, 32'h00000064};
        logic [3:0] s;
        for (int i = 0; i < 16; i++) begin
            s = i[3:0];
            mon_case({11'h000, 4'h2, s, s[0], 12'h4E0 + {8'h00, s}}, s[1] ? 32'hFFC00000 : 32'h00800000);
        end
        for (int i = 0; i < 7; i++) begin
            mon_case(tc[i], tv[i]);
        end
    endtask : t_monitor

    task automatic t_timeout();
        logic [11:0] pin0;
        int n;
        pin0 = monitor_output_pin;
        mute = 1'b1;
        acc(1'b0, 1'b1, `PGM_OFF_MON_CTRL, 32'h00111123);
        for (n = 0; n < 100 && monitor_fetch_timeout !== 1'b1; n++) step();
        check(monitor_fetch_timeout, 1'b1, "timeout");
        check(monitor_output_pin, pin0, "pin kept");
        mute = 1'b0;
    endtask : t_timeout

    initial begin
        repeat (6) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        t_reset();
        t_gains();
        t_ctrl();
        t_monitor();
        t_timeout();
        end_of_test();
    end
endmodule : pgm_regbank_test

bind pgm_regbank pgm_regbank_properties u_props (.clk_sys(clk_sys), .srst(srst), .reg_req(reg_req),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .gain_update(gain_update),
    .cur_integral_gain_used(cur_integral_gain_used), .cur_proportional_gain_used(cur_proportional_gain_used),
    .spd_integral_gain_used(spd_integral_gain_used), .spd_proportional_gain_used(spd_proportional_gain_used),
    .monitor_variable_address(monitor_variable_address), .var_rd_req(var_rd_req), .var_rd_data(var_rd_data),
    .var_rd_valid(var_rd_valid), .monitor_output_pin(monitor_output_pin),
    .monitor_out_update(monitor_out_update), .monitor_fetch_timeout(monitor_fetch_timeout));
`default_nettype wire
